// ==== tsc_status_control_regs.v ====
/*
 Status and control register bank of a multichannel time-to-digital converter.
 Assumes a decoded register port (select, write, 16-bit data, module-relative
 address) on clk_sys; readout-path and buffer signals come from logic on the
 same clock, chain lines and switches arrive from pins and are synchronised here.
 Block transfer words, the buffer itself and base address matching live
 elsewhere; this bank only raises the per-word controls they consume.
 Module reset, data clear and block error and pad outputs are one-cycle pulses.
 Straps are read once per hardware reset.
*/
// What this block does
// - Local ready when buffer holds an event
// - Chain ready is OR of chain ready lines
// - Busy on conversion, reset, full, memory test
// - Chain busy is OR of chain busy lines
// - Missing slot flag; slot then software writable
// - Purged flag once chained transfer finished
// - Terminations all on, all off, else mixed
// - Threshold flag when threshold meets count, irq
// - Block end zero: all data, error last
// - Block end one: stop at end word
// - Front reset mode: data or full reset
// - Bus error enable bit five gates errors
// - Alignment pads odd events with dummy word
// - Two base address registers relocate module
// - Any one-shot location write resets module
// - Two chain position flags encode board role
// - Five-bit threshold; zero disables interrupt
// - Second status shows buffer empty, full
// - Second status shows daughter board type
// - Counter low 16 bits readable, mode bit chosen
// - Counter clears on reset writes; data reset clears it only when counting accepted
// - Counting mode defaults to every trigger
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs_map.vh"

module tsc_status_control_regs #(
  parameter CNT_W = 24,
  parameter THR_W = 5,
  parameter [3:0] BOARD_TYPE = 4'h0  // Arbitrary value
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,

  // Register port
  input  wire        reg_sel,
  input  wire        reg_wr,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,

  // Buffer and conversion state, same clock
  input  wire        buf_has_event,
  input  wire        buf_empty,
  input  wire        buf_full,
  input  wire [4:0]  stored_events,
  input  wire        conversion_active,
  input  wire        memory_test_mode,
  input  wire        soft_reset_hold,
  input  wire        count_every_trigger,
  input  wire        data_reset,
  input  wire        counter_reset_wr,
  input  wire [2:0]  irq_level,

  // Event strobes
  input  wire        trigger_seen,
  input  wire        trigger_accepted,

  // Block readout side, same clock
  input  wire        chained_xfer,
  input  wire        chain_sent_all,
  input  wire        blk_read,
  input  wire        blk_last_word,
  input  wire        blk_word_is_end,
  input  wire        blk_event_odd,

  // Pins, asynchronous
  input  wire        chain_ready_line,
  input  wire        chain_busy_line,
  input  wire        term_all_on_sw,
  input  wire        term_all_off_sw,
  input  wire        slot_valid_pin,
  input  wire [4:0]  slot_pins,
  input  wire        front_reset_pin,
  input  wire [4:0]  slot_wdata,
  input  wire        slot_wr,

  // Outputs
  output reg         local_data_ready,
  output reg         local_busy,
  output reg         event_threshold_flag,
  output reg         irq_request,
  output reg         block_end_mode,
  output reg         front_reset_mode,
  output reg         bus_error_enable,
  output reg         align_pad_enable,
  output reg  [7:0]  base_addr_upper,
  output reg  [7:0]  base_addr_lower,
  output reg  [1:0]  chain_position,
  output reg  [4:0]  slot_number,
  output reg         slot_number_missing,
  output reg         module_reset,
  output reg         data_clear,
  output reg         blk_send_invalid,
  output reg         blk_bus_error,
  output reg         blk_pad_word,
  output reg  [CNT_W-1:0] event_count
);

  // ==========================================
  // Pin synchronisers
  // Bit order, low to high: ready, busy, on, off, valid, front
  localparam NSYNC = 6;
  wire [NSYNC-1:0] pin_raw = {front_reset_pin, slot_valid_pin, term_all_off_sw,
                              term_all_on_sw, chain_busy_line, chain_ready_line};
  reg  [NSYNC-1:0] sync1_reg;
  reg  [NSYNC-1:0] sync2_reg;
  reg  [4:0]       slot_s1_reg;
  reg  [4:0]       slot_s2_reg;
  reg              front_prev_reg;

  // Two stages per pin; only the second stage is read by logic.
  // Straps share the same depth so slot and valid settle together.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg   <= {NSYNC{1'b0}};
      sync2_reg   <= {NSYNC{1'b0}};
      slot_s1_reg <= 5'h00;
      slot_s2_reg <= 5'h00;
    end else begin
      sync1_reg   <= pin_raw;
      sync2_reg   <= sync1_reg;
      slot_s1_reg <= slot_pins;
      slot_s2_reg <= slot_s1_reg;
    end
  end

  wire chain_ready_s = sync2_reg[0];
  wire chain_busy_s  = sync2_reg[1];
  wire term_on_s     = sync2_reg[2];
  wire term_off_s    = sync2_reg[3];
  wire slot_valid_s  = sync2_reg[4];
  wire front_s       = sync2_reg[5];
  wire front_rise    = front_s & ~front_prev_reg;

  // Both switch lines high at once is a wiring fault: report mixed
  wire term_all_on   = term_on_s & ~term_off_s;
  wire term_all_off  = term_off_s & ~term_on_s;

  // ==========================================
  // Decode
  // Full 16-bit offset match; other offsets never hit a register
  wire wr_en   = reg_sel & reg_wr;
  wire wr_ct1  = wr_en & (reg_addr == `TSC_OFS_CONTROL_ONE);
  wire wr_bhi  = wr_en & (reg_addr == `TSC_OFS_BASE_UPPER);
  wire wr_blo  = wr_en & (reg_addr == `TSC_OFS_BASE_LOWER);
  wire wr_shot = wr_en & (reg_addr == `TSC_OFS_ONE_SHOT);
  wire wr_pos  = wr_en & (reg_addr == `TSC_OFS_CHAIN_POS);
  wire wr_thr  = wr_en & (reg_addr == `TSC_OFS_EVT_THRESH);

  // Module-wide soft reset: one-shot write or front panel in full mode
  // In data mode the front reset leaves every control bit alone
  wire soft_rst = wr_shot | (front_rise & front_reset_mode);
  wire dat_rst  = data_reset | (front_rise & ~front_reset_mode);

  reg [THR_W-1:0] thresh_reg;
  reg             purged_reg;
  reg             slot_caught_reg;
  reg  [1:0]      slot_settle_reg;

  // Control reset image, split into its fields below
  wire [6:0]      ct1_rst = `TSC_RST_CONTROL_ONE;

  // ==========================================
  // Control registers; hardware reset only, soft reset keeps them all
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      block_end_mode   <= ct1_rst[`TSC_CT1_BLOCK_END];
      front_reset_mode <= ct1_rst[`TSC_CT1_FRONT_RESET];
      bus_error_enable <= ct1_rst[`TSC_CT1_BUS_ERR_EN];
      align_pad_enable <= ct1_rst[`TSC_CT1_ALIGN];
      base_addr_upper  <= `TSC_RST_BASE;
      base_addr_lower  <= `TSC_RST_BASE;
      chain_position   <= `TSC_RST_CHAIN_POS;
      thresh_reg       <= `TSC_RST_EVT_THRESH;
      front_prev_reg   <= 1'b0;
    end else begin
      front_prev_reg <= front_s;
      if (wr_ct1) begin
        block_end_mode   <= reg_wdata[`TSC_CT1_BLOCK_END];
        front_reset_mode <= reg_wdata[`TSC_CT1_FRONT_RESET];
        bus_error_enable <= reg_wdata[`TSC_CT1_BUS_ERR_EN];
        align_pad_enable <= reg_wdata[`TSC_CT1_ALIGN];
      end
      // Base address bytes, upper then lower
      if (wr_bhi) begin
        base_addr_upper <= reg_wdata[7:0];
      end
      if (wr_blo) begin
        base_addr_lower <= reg_wdata[7:0];
      end
      // Chain role: bit 0 first board, bit 1 last board
      if (wr_pos) begin
        chain_position <= reg_wdata[1:0];
      end
      // Threshold keeps only its low bits; upper data bits are dropped
      if (wr_thr) begin
        thresh_reg <= reg_wdata[THR_W-1:0];
      end
    end
  end

  // ==========================================
  // Slot number: caught once after release, writable when missing.
  // Straps are sampled only after the synchroniser has refilled
  // from the pins, so no reset value of the flops leaks into the slot.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      slot_number         <= `TSC_SLOT_DEFAULT;
      slot_number_missing <= 1'b0;
      slot_caught_reg     <= 1'b0;
      slot_settle_reg     <= 2'h0;
    end else if (!slot_caught_reg) begin
      // Count the refill cycles, then take the straps once
      if (slot_settle_reg != `TSC_SLOT_SETTLE) begin
        slot_settle_reg <= slot_settle_reg + 2'h1;
      end else begin
        slot_caught_reg     <= 1'b1;
        slot_number_missing <= ~slot_valid_s;
        if (slot_valid_s)
          slot_number <= slot_s2_reg;
      end
    end else if (slot_number_missing && slot_wr) begin
      slot_number <= slot_wdata;
    end
  end

  // ==========================================
  // Event counter clear and step conditions.
  // A data reset clears only the relative count of accepted events;
  // counting every trigger keeps the absolute count across data resets.
  wire cnt_full_clr = ~rst_n | soft_rst | counter_reset_wr | soft_reset_hold;
  wire cnt_data_clr = dat_rst & ~count_every_trigger;
  wire cnt_step     = count_every_trigger ? trigger_seen : trigger_accepted;

  // Event counter, wraps silently at full scale
  always @(posedge clk_sys) begin
    if (cnt_full_clr)
      event_count <= {CNT_W{1'b0}};
    else if (cnt_data_clr)
      event_count <= {CNT_W{1'b0}};
    else if (cnt_step)
      event_count <= event_count + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // ==========================================
  // Status, threshold and block readout controls
  // Both sides at eight bits so the compare is unsigned and equal width
  wire [7:0] thr_wide  = {{(8-THR_W){1'b0}}, thresh_reg};
  wire [7:0] evt_wide  = {3'b000, stored_events};
  // Zero threshold or zero level keeps flag and request quiet
  wire       thr_armed = (thresh_reg != {THR_W{1'b0}}) && (irq_level != 3'd0);
  wire       thr_hit   = thr_armed && (thr_wide >= evt_wide);
  wire       thr_match = thr_armed && (thr_wide == evt_wide);

  // Busy sources; any of them holds the module busy
  wire       busy_src  = conversion_active | soft_reset_hold | module_reset
                         | dat_rst | buf_full | memory_test_mode;

  // Block readout stops on the end word or on the last buffered word
  wire       blk_stop  = block_end_mode ? blk_word_is_end : blk_last_word;

  // ==========================================
  // Status and block readout flops

  always @(posedge clk_sys) begin
    // Busy stands through reset; flags and pulses drop, module_reset rises on soft reset
    if (!rst_n || soft_rst) begin
      local_data_ready     <= 1'b0;
      local_busy           <= 1'b1;
      event_threshold_flag <= 1'b0;
      irq_request          <= 1'b0;
      purged_reg           <= 1'b0;
      module_reset         <= ~rst_n ? 1'b0 : 1'b1;
      data_clear           <= 1'b0;
      blk_send_invalid     <= 1'b0;
      blk_bus_error        <= 1'b0;
      blk_pad_word         <= 1'b0;
    end else begin
      local_data_ready <= buf_has_event;
      local_busy       <= busy_src;
      event_threshold_flag <= thr_hit;
      // Request on exact match; zero threshold disables it
      irq_request      <= thr_match;
      // Purged only while a chained transfer has sent everything
      purged_reg   <= chained_xfer & chain_sent_all;
      module_reset <= 1'b0;
      data_clear   <= dat_rst;
      // Invalid words after end word or once empty
      if (!chained_xfer && !blk_read)
        blk_send_invalid <= 1'b0;
      else if (blk_read && block_end_mode && blk_word_is_end)
        blk_send_invalid <= 1'b1;
      else if (blk_read && !block_end_mode && blk_last_word)
        blk_send_invalid <= 1'b1;
      // Bus error only when enabled; else every cycle acknowledged
      // Chained transfers keep the invalid marker up between words
      blk_bus_error <= bus_error_enable & blk_read & blk_stop;
      blk_pad_word  <= align_pad_enable & blk_read & blk_word_is_end & blk_event_odd;
    end
  end

  // ==========================================
  // Read data for the addressed register, zero for unmapped offsets.
  // Read-only offsets have no write path, so writes there change nothing.
  reg [15:0] rd_next;

  always @* begin
    rd_next = 16'h0000;
    case (reg_addr)
      `TSC_OFS_STATUS_ONE: begin
        rd_next[`TSC_ST1_LOCAL_DATA_READY]       = local_data_ready;
        rd_next[`TSC_ST1_CHAIN_LOCAL_DATA_READY] = chain_ready_s;
        rd_next[`TSC_ST1_BUSY]         = local_busy;
        rd_next[`TSC_ST1_CHAIN_BUSY]   = chain_busy_s;
        rd_next[`TSC_ST1_SLOT_MISSING] = slot_number_missing;
        rd_next[`TSC_ST1_PURGED]       = purged_reg;
        rd_next[`TSC_ST1_TERM_ON]      = term_all_on;
        rd_next[`TSC_ST1_TERM_OFF]     = term_all_off;
        rd_next[`TSC_ST1_EVT_FLAG]     = event_threshold_flag;
      end
      `TSC_OFS_CONTROL_ONE: begin
        rd_next[`TSC_CT1_BLOCK_END]   = block_end_mode;
        rd_next[`TSC_CT1_FRONT_RESET] = front_reset_mode;
        rd_next[`TSC_CT1_BUS_ERR_EN]  = bus_error_enable;
        rd_next[`TSC_CT1_ALIGN]       = align_pad_enable;
      end
      `TSC_OFS_BASE_UPPER:  rd_next = {8'h00, base_addr_upper};
      `TSC_OFS_BASE_LOWER:  rd_next = {8'h00, base_addr_lower};
      `TSC_OFS_CHAIN_POS:   rd_next = {14'h0000, chain_position};
      `TSC_OFS_EVT_THRESH:  rd_next = {{(16-THR_W){1'b0}}, thresh_reg};
      `TSC_OFS_STATUS_TWO: begin
        rd_next[`TSC_ST2_EMPTY] = buf_empty;
        rd_next[`TSC_ST2_FULL]  = buf_full;
        rd_next[`TSC_ST2_BOARD_LSB+3:`TSC_ST2_BOARD_LSB] = BOARD_TYPE;
      end
      `TSC_OFS_EVT_CNT_LOW: rd_next = event_count[15:0];
      default:              rd_next = 16'h0000;
    endcase
  end

  // ==========================================
  // Read data register; holds until the next read
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_sel && !reg_wr) begin
      reg_rdata <= rd_next;
    end
  end

  // ==========================================
  // Limitations
  // Slot writes take effect at once; the slot is caught only once
  // per hardware reset, so a soft reset keeps a written slot.
  // Base address bytes only hold the value; matching is done upstream.
  // Reading two registers back to back needs no idle cycle; each result lands one cycle later.

endmodule // tsc_status_control_regs
`default_nettype wire

// ==== tsc_regs_map.vh ====
/*
 Register offsets, field positions and reset values of the status and control bank.
 Assumes offsets are compared against the low 16 bits of the module-relative address.
*/
`ifndef TSC_REGS_MAP_VH
`define TSC_REGS_MAP_VH
// ==========================================
// Offsets
`define TSC_OFS_STATUS_ONE   16'h100E
`define TSC_OFS_CONTROL_ONE  16'h1010
`define TSC_OFS_BASE_UPPER   16'h1012
`define TSC_OFS_BASE_LOWER   16'h1014
`define TSC_OFS_ONE_SHOT     16'h1016
`define TSC_OFS_CHAIN_POS    16'h101A
`define TSC_OFS_EVT_THRESH   16'h1020
`define TSC_OFS_STATUS_TWO   16'h1022
`define TSC_OFS_EVT_CNT_LOW  16'h1024
// ==========================================
// Status one field positions
`define TSC_ST1_LOCAL_DATA_READY       0
`define TSC_ST1_CHAIN_LOCAL_DATA_READY 1
`define TSC_ST1_BUSY         2
`define TSC_ST1_CHAIN_BUSY   3
`define TSC_ST1_SLOT_MISSING 4
`define TSC_ST1_PURGED       5
`define TSC_ST1_TERM_ON      6
`define TSC_ST1_TERM_OFF     7
`define TSC_ST1_EVT_FLAG     8
// ==========================================
// Control one field positions
`define TSC_CT1_BLOCK_END    2
`define TSC_CT1_FRONT_RESET  4
`define TSC_CT1_BUS_ERR_EN   5
`define TSC_CT1_ALIGN        6
// ==========================================
// Status two field positions
`define TSC_ST2_EMPTY        1
`define TSC_ST2_FULL         2
`define TSC_ST2_BOARD_LSB    4
// ==========================================
// Reset values
`define TSC_RST_CONTROL_ONE  7'h00
`define TSC_RST_BASE         8'h00
`define TSC_RST_CHAIN_POS    2'h0
`define TSC_RST_EVT_THRESH   5'h00
`define TSC_SLOT_DEFAULT     5'h1F
// ==========================================
// Timing counts
`define TSC_SLOT_SETTLE      2'h3
`endif

// ==== tsc_regs_assertions.sv ====
/* Concurrent checks on the ports of the status and control bank.
   Assumes a bind onto the bank, one clock and a synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module tsc_regs_assertions #(
  parameter CNT_W = 24
) (
  // Clock, reset and register port
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic             reg_sel,
  input wire logic             reg_wr,
  input wire logic [15:0]      reg_addr,
  input wire logic [15:0]      reg_wdata,
  // Status and event inputs
  input wire logic             buf_has_event,
  input wire logic             buf_full,
  input wire logic             conversion_active,
  input wire logic             trigger_seen,
  input wire logic             trigger_accepted,
  input wire logic             count_every_trigger,
  input wire logic             data_reset,
  input wire logic             counter_reset_wr,
  // Bank outputs
  input wire logic             local_data_ready,
  input wire logic             local_busy,
  input wire logic             block_end_mode,
  input wire logic             front_reset_mode,
  input wire logic             bus_error_enable,
  input wire logic [7:0]       base_addr_upper,
  input wire logic             module_reset,
  input wire logic [CNT_W-1:0] event_count
);
  // ==========================================
  // Helpers
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] wd_q;
  wire         wr_hit = reg_sel && reg_wr;
  // Counter is quiet only with no strobe of any kind
  wire         quiet = !trigger_seen && !trigger_accepted && !data_reset && !counter_reset_wr && !module_reset;
  // Write data one cycle back, so bit fields can be compared
  always @(posedge clk_sys) begin
    wd_q <= reg_wdata;
  end
  // ==========================================
  // Assertions
  AST_READY:
  assert property (!module_reset && !$past(module_reset) && $stable(buf_has_event) |-> local_data_ready == buf_has_event) else $error("ready flag wrong");
  AST_BUSY:
  assert property (conversion_active || buf_full |=> local_busy) else $error("busy not raised");
  AST_CTRL_WRITE:
  assert property (wr_hit && reg_addr == 16'h1010 |=> block_end_mode == wd_q[2] && front_reset_mode == wd_q[4]
    && bus_error_enable == wd_q[5]) else $error("control bits not taken");
  AST_BASE_WRITE:
  assert property (wr_hit && reg_addr == 16'h1012 |=> base_addr_upper == wd_q[7:0]) else $error("base upper not taken");
  AST_ONE_SHOT:
  assert property (wr_hit && reg_addr == 16'h1016 |=> module_reset ##1 !module_reset) else $error("no reset pulse");
  AST_MODE_KEEP:
  assert property (module_reset |=> $stable(front_reset_mode)) else $error("reset mode lost");
  AST_COUNT_ALL:
  assert property (count_every_trigger && trigger_seen && !trigger_accepted && !data_reset && !counter_reset_wr
    && !module_reset |=> event_count == $past(event_count) + 1'h1) else $error("count missed");
  AST_COUNT_CLEAR:
  assert property (counter_reset_wr |=> event_count == '0) else $error("count not cleared");
  AST_RO_WRITE:
  assert property (wr_hit && (reg_addr == 16'h1024 || reg_addr == 16'h100E) && quiet |=> $stable(event_count))
    else $error("read-only write changed count");
  // Coverage of the main scenarios
  COV_ONE_SHOT: cover property (wr_hit && reg_addr == 16'h1016);
  COV_COUNT: cover property (trigger_seen && count_every_trigger);
  COV_RESET: cover property (module_reset ##1 !module_reset);
endmodule  // tsc_regs_assertions
`default_nettype wire

// ==== tsc_host_model.sv ====
/* Bus master model: single register reads and writes.
   Assumes the bench calls access; lines move on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Register port
  output var  logic        reg_sel,
  output var  logic        reg_wr,
  output var  logic [15:0] reg_addr,
  output var  logic [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // Idle port at time zero
  initial begin
    reg_sel = 1'h0;
    reg_wr = 1'h0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // One access; idle lines show inverted values so nothing stale matches
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wd, output logic [15:0] rd);
    @(negedge clk_sys);
    {reg_sel, reg_wr, reg_addr, reg_wdata} = {1'h1, wr, addr, wd};
    @(negedge clk_sys);
    rd = reg_rdata;
    {reg_sel, reg_wr, reg_addr, reg_wdata} = {1'h0, ~wr, ~addr, ~wd};
  endtask
endmodule  // tsc_host_model
`default_nettype wire

// ==== tsc_status_control_regs_bench.sv ====
/* Self-checking bench for the status and control bank.
   Assumes the host model drives the register port; all else is driven here. */
`timescale 1ns/1ps
`default_nettype none
module tsc_status_control_regs_bench;
  // ==========================================
  // Stimulus, all given values at time zero
  logic clk_sys = 1'h0, rst_n = 1'h0, buf_has_event = 1'h0, buf_empty = 1'h1, buf_full = 1'h0, slot_wr = 1'h0;
  logic conversion_active = 1'h0, memory_test_mode = 1'h0, soft_reset_hold = 1'h0, count_every_trigger = 1'h1;
  logic data_reset = 1'h0, counter_reset_wr = 1'h0, trigger_seen = 1'h0, trigger_accepted = 1'h0, blk_read = 1'h0;
  logic chained_xfer = 1'h0, chain_sent_all = 1'h0, blk_last_word = 1'h0, blk_word_is_end = 1'h0, blk_event_odd = 1'h0;
  logic chain_ready_line = 1'h0, chain_busy_line = 1'h0, term_all_on_sw = 1'h0, term_all_off_sw = 1'h0;
  logic slot_valid_pin = 1'h0, front_reset_pin = 1'h0;
  logic [4:0] stored_events = 5'h00, slot_pins = 5'h00, slot_wdata = 5'h00;
  logic [2:0] irq_level = 3'h0;
  logic       inv_seen = 1'h0;
  // Register port and bank outputs
  wire [15:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_sel, reg_wr, local_data_ready, local_busy, event_threshold_flag, irq_request, block_end_mode;
  wire        front_reset_mode, bus_error_enable, align_pad_enable, slot_number_missing, module_reset, data_clear;
  wire        blk_send_invalid, blk_bus_error, blk_pad_word;
  wire [7:0]  base_addr_upper, base_addr_lower;
  wire [4:0]  slot_number;
  wire [1:0]  chain_position;
  wire [23:0] event_count;
  wire [3:0]  pulses = {module_reset, data_clear, blk_bus_error, blk_pad_word};
  int         bad_count = 0, n_tests = 0;
  tsc_status_control_regs dut (.*);
  tsc_host_model host (.*);
  // 200 MHz clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] x;
    host.access(1'h1, a, d, x);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.access(1'h0, a, 16'h0000, d);
    chk(d, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Pulses are short, so gather them over a fixed window
  task automatic pulse_chk(input logic [3:0] mask, input logic [3:0] exp);
    logic [3:0] acc;
    acc = 4'h0;
    repeat (8) begin
      acc = acc | pulses;
      @(negedge clk_sys);
    end
    chk(acc & mask, exp);
  endtask
  task automatic strobe(input logic [3:0] s);
    @(negedge clk_sys);
    {trigger_seen, trigger_accepted, data_reset, counter_reset_wr} = s;
    @(negedge clk_sys);
    {trigger_seen, trigger_accepted, data_reset, counter_reset_wr} = 4'h0;
  endtask
  task automatic blk_word(input logic [2:0] kind, input logic [3:0] exp);
    {blk_last_word, blk_word_is_end, blk_event_odd, blk_read} = {kind, 1'h1};
    @(negedge clk_sys);
    inv_seen = blk_send_invalid;
    blk_read = 1'h0;
    pulse_chk(4'h3, exp);
  endtask
  task automatic front_pulse(input logic [3:0] mask, input logic [3:0] exp);
    front_reset_pin = 1'h1;
    wait_n(2);
    front_reset_pin = 1'h0;
    pulse_chk(mask, exp);
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_status;
    rd_chk(16'h1020, 16'h0000);
    rd_chk(16'h1022, 16'h0002);
    {buf_has_event, chain_ready_line, conversion_active, chain_busy_line, chained_xfer, chain_sent_all} = 6'h3F;
    term_all_on_sw = 1'h1;
    wait_n(5);
    rd_chk(16'h100E, 16'h007F);
    {buf_has_event, chain_ready_line, conversion_active, chain_busy_line, chained_xfer, chain_sent_all} = 6'h00;
    {term_all_on_sw, buf_full, buf_empty, term_all_off_sw} = 4'h5;
    wait_n(5);
    rd_chk(16'h100E, 16'h0094);
    rd_chk(16'h1022, 16'h0004);
    {buf_full, memory_test_mode} = 2'h1;
    wait_n(2);
    chk(local_busy, 1'h1);
    {memory_test_mode, soft_reset_hold, slot_wdata, slot_wr} = {2'h1, 5'h0A, 1'h1};
    wait_n(2);
    chk({slot_number, local_busy}, {5'h0A, 1'h1});
    {soft_reset_hold, slot_wr} = 2'h0;
    $display("done: status");
  endtask
  task automatic t_control;
    wr(16'h1010, 16'hFFFF);
    rd_chk(16'h1010, 16'h0074);
    wr(16'h1012, 16'h12AB);
    wr(16'h1014, 16'h3456);
    chk({base_addr_upper, base_addr_lower}, 16'hAB56);
    rd_chk(16'h1014, 16'h0056);
    wr(16'h1020, 16'hFFFF);
    rd_chk(16'h1020, 16'h001F);
    for (int i = 0; i < 4; i++) begin
      wr(16'h101A, 16'(i));
      rd_chk(16'h101A, 16'(i));
      chk(chain_position, 16'(i));
    end
    wr(16'h1022, 16'hFFFF);
    rd_chk(16'h1022, 16'h0000);
    rd_chk(16'h1030, 16'h0000);
    $display("done: control");
  endtask
  task automatic t_counter;
    repeat (3) strobe(4'h8);
    wr(16'h1024, 16'hFFFF);
    wr(16'h100E, 16'hFFFF);
    rd_chk(16'h1024, 16'h0003);
    count_every_trigger = 1'h0;
    strobe(4'h8);
    strobe(4'hC);
    rd_chk(16'h1024, 16'h0004);
    strobe(4'h2);
    rd_chk(16'h1024, 16'h0000);
    count_every_trigger = 1'h1;
    strobe(4'h8);
    strobe(4'h1);
    rd_chk(16'h1024, 16'h0000);
    $display("done: counter");
  endtask
  task automatic t_thresh_block;
    wr(16'h1020, 16'h0002);
    {irq_level, stored_events} = {3'h1, 5'h02};
    wait_n(2);
    chk(event_threshold_flag, 1'h1);
    stored_events = 5'h03;
    wait_n(2);
    chk(event_threshold_flag, 1'h0);
    wr(16'h1010, 16'h0060);
    blk_word(3'h4, 4'h2);
    chk(inv_seen, 1'h1);
    blk_word(3'h3, 4'h1);
    chk(inv_seen, 1'h0);
    wr(16'h1010, 16'h0024);
    blk_word(3'h2, 4'h2);
    chk(inv_seen, 1'h1);
    wr(16'h1010, 16'h0004);
    blk_word(3'h2, 4'h0);
    $display("done: threshold and block");
  endtask
  task automatic t_resets;
    wr(16'h1010, 16'h0010);
    strobe(4'h8);
    wr(16'h1016, 16'h0000);
    pulse_chk(4'h8, 4'h8);
    chk(front_reset_mode, 1'h1);
    rd_chk(16'h1024, 16'h0000);
    front_pulse(4'h8, 4'h8);
    wr(16'h1010, 16'h0000);
    front_pulse(4'hC, 4'h4);
    $display("done: resets");
  endtask
  // Main sequence: reset for four cycles, then each scenario
  initial begin
    wait_n(4);
    rst_n = 1'h1;
    wait_n(4);
    t_status;
    t_control;
    t_counter;
    t_thresh_block;
    t_resets;
    close_out;
  end
endmodule  // tsc_status_control_regs_bench
bind tsc_status_control_regs tsc_regs_assertions #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire
